// ==== core/selfcal_ctrl.sv ====
// Delay line self-calibration control and status over AXI4-Lite
// Assumes an external calibration engine answering with a done pulse
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "selfcal_map.svh"
module ddr_dll_self_calibration_ctrl #(
  parameter int unsigned DYN_PERIOD = `DYN_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // AXI4-Lite write
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // Calibration engine
  output selfcal_pkg::cal_req_t     cal_req,
  output logic                      dynamic_cal_enable,
  input  wire selfcal_pkg::cal_rsp_t cal_rsp,
  // Interrupt
  output logic                      irq
);
  import selfcal_pkg::*;

  // Reset image of the control word
  localparam logic [31:0] CTRL_RESET = `CTRL_RST;

  // ==========================================================
  // Registers
  logic        phase_q;
  logic        dyn_q;
  logic        ub_ok_q;
  logic        lb_ok_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_msk_q;
  cal_state_t  state_q;
  logic        go_pulse;
  logic        tick;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] ctrl_rd;
  logic        cal_finish;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  // Any offset the block answers
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `CAL_CTRL_OFS) || hit(a, `CAL_IRQST_OFS)
             || hit(a, `CAL_IRQMSK_OFS);
  endfunction

  // ==========================================================
  // Write channel: address and data in either order
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      // One-cycle ready pulse, so a held valid is taken once
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped offsets answer SLVERR and change nothing
        s_axi_bresp  <= mapped(aw_addr_q) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control bits
  // Start is self-clearing, so it never reads back as one
  assign go_pulse = wr_fire && hit(aw_addr_q, `CAL_CTRL_OFS)
                    && w_strb_q[3] && w_data_q[`GO_BIT];

  // Only lane 3 holds writable control fields
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= CTRL_RESET[`PHASE_BIT];
      dyn_q   <= CTRL_RESET[`DYN_BIT];
    end
    else if (wr_fire && hit(aw_addr_q, `CAL_CTRL_OFS) && w_strb_q[3])
    begin
      phase_q <= w_data_q[`PHASE_BIT];
      dyn_q   <= w_data_q[`DYN_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_msk_q <= `MASK_RST;
    else if (wr_fire && hit(aw_addr_q, `CAL_IRQMSK_OFS) && w_strb_q[0])
      irq_msk_q <= w_data_q[1:0];
  end

  // ==========================================================
  // Calibration sequencing
  // Ticks landing mid-run are dropped, so periods may stretch
  selfcal_timer #(
    .PERIOD (DYN_PERIOD)
  ) u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .run    (dyn_q),
    .tick_q (tick)
  );

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_IDLE;
      cal_req  <= '0;
    end
    else
    begin
      // Engine sees phase enable as a level, start as a pulse
      cal_req.phase_en <= phase_q;
      cal_req.go       <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          // Periodic relaunch while dynamic mode is on
          if (go_pulse || (dyn_q && tick))
          begin
            cal_req.go <= 1'b1;
            state_q    <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // No timeout: a silent engine parks the sequencer here
          if (cal_rsp.done)
            state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          // One idle cycle lets the status settle before a relaunch
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dynamic_cal_enable <= 1'b0;
    else
      // Flop copy so the engine never sees a decode glitch
      dynamic_cal_enable <= dyn_q;
  end

  // Result lines are only trusted with done while a run is open
  assign cal_finish = (state_q == ST_RUN) && cal_rsp.done;

  // ==========================================================
  // Pass status, updated only at completion
  // A failed lane is written back as zero, not left stale
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ub_ok_q <= CTRL_RESET[`UB_BIT];
      lb_ok_q <= CTRL_RESET[`LB_BIT];
    end
    else if (cal_finish)
    begin
      ub_ok_q <= cal_rsp.upper_ok;
      lb_ok_q <= cal_rsp.lower_ok;
    end
  end

  // ==========================================================
  // Read channel
  // Data is a snapshot taken at the address handshake
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    ctrl_rd = 32'h0;
    ctrl_rd[`PHASE_BIT] = phase_q;
    ctrl_rd[`DYN_BIT]   = dyn_q;
    ctrl_rd[`UB_BIT]    = ub_ok_q;
    ctrl_rd[`LB_BIT]    = lb_ok_q;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (hit(s_axi_araddr, `CAL_CTRL_OFS))
          s_axi_rdata <= ctrl_rd;
        else if (hit(s_axi_araddr, `CAL_IRQST_OFS))
          s_axi_rdata <= {30'h0, irq_st_q};
        else if (hit(s_axi_araddr, `CAL_IRQMSK_OFS))
          s_axi_rdata <= {30'h0, irq_msk_q};
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status: read clears, a new event wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_st_q <= 2'h0;
    else
    begin
      if (rd_fire && hit(s_axi_araddr, `CAL_IRQST_OFS))
        irq_st_q <= 2'h0;
      if (cal_finish)
      begin
        irq_st_q[`IRQ_DONE] <= 1'b1;
        if (!(cal_rsp.upper_ok && cal_rsp.lower_ok))
          irq_st_q[`IRQ_FAIL] <= 1'b1;
      end
    end
  end

  // Registered pin: glitch free, one cycle behind the status
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_st_q & irq_msk_q);
  end
endmodule

// ==== core/selfcal_map.svh ====
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit AXI4-Lite slave at 50 MHz
`ifndef SELFCAL_MAP_SVH
`define SELFCAL_MAP_SVH

// ==========================================================
// Offsets
`define CAL_CTRL_OFS   8'h00
`define CAL_IRQST_OFS  8'h04
`define CAL_IRQMSK_OFS 8'h08

// ==========================================================
// Field positions
`define PHASE_BIT  29
`define GO_BIT     28
`define DYN_BIT    26
`define UB_BIT     1
`define LB_BIT     0
`define IRQ_DONE   0
`define IRQ_FAIL   1

// ==========================================================
// Reset values and timing
`define CTRL_RST   32'h0000_0000
`define MASK_RST   2'h0
`define DYN_PERIOD_US 100
`define DYN_PERIOD_CYC ((`DYN_PERIOD_US * 50))

`endif

// ==== core/selfcal_pkg.sv ====
// Types for the delay line calibration control block
// Assumes selfcal_map.svh for numbers
package selfcal_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } cal_state_t;

  // Request to and result from the calibration engine
  typedef struct packed {
    logic go;
    logic phase_en;
  } cal_req_t;

  typedef struct packed {
    logic done;
    logic upper_ok;
    logic lower_ok;
  } cal_rsp_t;
endpackage

// ==== core/selfcal_timer.sv ====
// Up counter pacing dynamic recalibration
// Assumes a single clock domain
`timescale 1ns/100ps
module selfcal_timer #(
  parameter int unsigned PERIOD = 5000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  output logic      tick_q
);
  logic [31:0] cnt_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (cnt_q == PERIOD - 1)
    begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule

// ==== dv/cal_engine_model.sv ====
// Behavioural calibration engine answering go pulses
// Assumes latency and result are set by the bench
`timescale 1ns/100ps
module cal_engine_model (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Block side
  input wire selfcal_pkg::cal_req_t cal_req,
  output selfcal_pkg::cal_rsp_t     cal_rsp,
  // Bench control
  input wire logic [3:0] lat,
  input wire logic [1:0] res
);
  import selfcal_pkg::*;
  logic [3:0] cnt_q;
  logic       busy_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      busy_q  <= 1'b0;
      cnt_q   <= 4'h0;
      cal_rsp <= '0;
    end
    else
    begin
      // Idle result lines carry junk, not the last answer
      cal_rsp <= {1'b0, ~res};
      if (cal_req.go && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q  <= lat;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        busy_q  <= 1'b0;
        cal_rsp <= {1'b1, res};
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
endmodule

// ==== dv/ddr_dll_self_calibration_ctrl_test.sv ====
// Self-checking bench for the calibration control block
// Assumes the engine model and the checker compile first
`timescale 1ns/100ps
module ddr_dll_self_calibration_ctrl_test;
  import selfcal_pkg::*;
  logic        clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic        dynamic_cal_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, lat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, res;
  cal_req_t    cal_req;
  cal_rsp_t    cal_rsp;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  int          bad_count, compares, seed, n, go_count, gc;
  ddr_dll_self_calibration_ctrl #(.DYN_PERIOD(8)) i_dut (.clock, .rst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cal_req,
    .dynamic_cal_enable, .cal_rsp, .irq);
  cal_engine_model i_eng (.clock, .rst_n, .cal_req, .cal_rsp, .lat, .res);
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ====
  // Compare, verdict and bus tasks
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bexp_q.push_back((a > 8'h08) ? 2'h2 : 2'h0);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    for (n = 0; !(s_axi_bvalid && s_axi_bready); n++)
    begin
      if (n > 40) give_up();
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  // Expectation is queued; the watcher below compares it
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clock);
    exp_q.push_back(e);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    for (n = 0; !(s_axi_rvalid && s_axi_rready); n++)
    begin
      if (n > 40) give_up();
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge clock)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready && bexp_q.size() > 0)
      check({32'h0, s_axi_bresp}, {32'h0, bexp_q.pop_front()});
  end
  // Start pulses seen by the engine
  always @(posedge clock)
    if (cal_req.go === 1'b1)
      go_count++;
  // ====
  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, rst_n} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, lat, res} = {32'h0, 4'hF, 4'h1, 2'h0};
    seed = 15504;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h00, 34'h0);
    wr(8'h00, 32'h2000_0000);
    rd(8'h00, 34'h0_2000_0000);
    check({33'h0, cal_req.phase_en}, 34'h1);
    check(34'(go_count), 34'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h08, (i == 0) ? 32'h0 : 32'h3);
      res <= 2'(i);
      lat <= 4'($random(seed));
      wr(8'h00, 32'h3000_0000);
      for (n = 0; !cal_rsp.done; n++)
      begin
        if (n > 40) give_up();
        @(posedge clock);
      end
      repeat (2) @(posedge clock);
      check({33'h0, irq}, {33'h0, i != 0});
      check(34'(go_count), 34'(i + 1));
      rd(8'h04, {32'h0, i != 3, 1'b1});
      rd(8'h00, 34'h0_2000_0000 | 34'(i));
    end
    $display("test calibration done");
    rd(8'h0C, {2'h2, 32'h0});
    wr(8'h0C, 32'h0);
    lat <= 4'h1;
    wr(8'h00, 32'h0400_0000);
    rd(8'h00, 34'h0_0400_0003);
    check({33'h0, dynamic_cal_enable}, 34'h1);
    check({33'h0, cal_req.phase_en}, 34'h0);
    for (n = 0; !cal_req.go; n++)
    begin
      if (n > 60) give_up();
      @(posedge clock);
    end
    @(posedge clock);
    check(34'(go_count), 34'h5);
    wr(8'h00, 32'h0);
    @(posedge clock);
    gc = go_count;
    repeat (40) @(posedge clock);
    check(34'(go_count), 34'(gc));
    check({33'h0, dynamic_cal_enable}, 34'h0);
    $display("test dynamic done");
    end_of_test();
  end
endmodule

// ==== dv/selfcal_ctrl_assertions.sv ====
// Checker on the calibration control ports
// Assumes the package is compiled first
`timescale 1ns/100ps
module selfcal_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  // Engine
  input wire selfcal_pkg::cal_req_t cal_req,
  input wire logic        dynamic_cal_enable,
  input wire selfcal_pkg::cal_rsp_t cal_rsp
);
  import selfcal_pkg::*;
  logic [7:0] ra_q;
  logic [2:0] ok_q;
  wire        rd_ctrl = s_axi_rvalid && ra_q == 8'h00;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ====
  // Last read address and last engine result
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      ra_q <= 8'h00;
      ok_q <= 3'h0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        ra_q <= s_axi_araddr;
      if (cal_rsp.done)
        ok_q <= {1'b1, cal_rsp.upper_ok, cal_rsp.lower_ok};
    end
  // ====
  // Properties
  // Enables move one cycle after the write response is raised
  property p_phase; $changed(cal_req.phase_en) |-> $past(s_axi_bvalid);
  endproperty
  a_phase: assert property (p_phase) else $error("phase moved");
  property p_go; cal_req.go |=> !cal_req.go; endproperty
  a_go: assert property (p_go) else $error("go too long");
  property p_dyn; $changed(dynamic_cal_enable) |-> $past(s_axi_bvalid);
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic moved");
  property p_ub; rd_ctrl |-> s_axi_rdata[1] == ok_q[1]; endproperty
  a_ub: assert property (p_ub) else $error("upper pass wrong");
  property p_lb; rd_ctrl |-> s_axi_rdata[0] == ok_q[0]; endproperty
  a_lb: assert property (p_lb) else $error("lower pass wrong");
  property p_rst; rd_ctrl && !ok_q[2] |-> s_axi_rdata[1:0] == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pass before done");
endmodule
bind ddr_dll_self_calibration_ctrl selfcal_checker i_chk (.clock, .rst_n,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_bvalid, .cal_req, .dynamic_cal_enable, .cal_rsp);
